// File: rtl/uic_irq_ident.sv
// Interrupt identification and line control for one UART channel.
// Assumes interrupt sources arrive already enabled and synchronous to clk.
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module uic_irq_ident (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic fifo_enabled,
  input wire logic line_status_error,
  input wire logic receive_data_ready,
  input wire logic receive_timeout,
  input wire logic transmit_holding_empty,
  input wire logic modem_status_change,
  input wire logic xoff_detected,
  input wire logic xon_received,
  input wire logic flow_change,
  input wire logic tx_serial,
  output logic irq,
  output logic tx_line,
  output logic [15:0] divisor,
  output logic enhanced_mode,
  output logic parity_enable,
  output logic parity_even,
  output logic parity_forced,
  output logic parity_force_value,
  output logic [3:0] word_bits,
  output logic [2:0] stop_halves
);
  typedef struct packed {
    uic_pkg::uic_arb_t arb;
    logic [2:0] held;
    logic xoff_flag;
    logic [7:0] line_ctl;
    logic [7:0] feature;
    logic [7:0] div_low;
    logic [7:0] div_high;
    logic [7:0] rdata;
    logic irq;
  } uic_state_t;

  logic [1:0] rst_pipe;
  logic rst_sync_n;
  uic_state_t st;
  uic_state_t next_st;
  logic [uic_pkg::NUM_SRC-1:0] pend;
  logic pick_any;
  logic [2:0] pick_sel;
  logic enh;
  logic dlab;
  logic [5:0] ident_code;

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe[1];

  assign enh = st.feature[uic_pkg::EFR_ENH];
  assign dlab = st.line_ctl[uic_pkg::LCR_DLAB];

  // Pending sources in priority order
  always_comb begin
    pend = '0;
    pend[uic_pkg::SRC_LINE] = line_status_error;
    pend[uic_pkg::SRC_TIMEOUT] = receive_timeout;
    pend[uic_pkg::SRC_RXDATA] = receive_data_ready;
    pend[uic_pkg::SRC_THR] = transmit_holding_empty;
    pend[uic_pkg::SRC_MODEM] = modem_status_change;
    pend[uic_pkg::SRC_XOFF] = st.xoff_flag & enh;
    pend[uic_pkg::SRC_FLOW] = flow_change & enh;
  end

  uic_prio_pick u_pick (
    .pending(pend),
    .any(pick_any),
    .sel(pick_sel)
  );

  // Bits 5 and 4 drop at once when enhanced mode is turned off
  assign ident_code = (st.arb == uic_pkg::UIC_HELD) ?
    (uic_pkg::uic_code_of(st.held) & {enh, enh, 4'hf}) : uic_pkg::CODE_NONE;

  always_comb begin
    next_st = st;
    // Arbitration: hold the presented source until it is serviced
    unique case (st.arb)
      uic_pkg::UIC_IDLE: begin
        if (pick_any) begin
          next_st.arb = uic_pkg::UIC_HELD;
          next_st.held = pick_sel;
        end
      end
      uic_pkg::UIC_HELD: begin
        if (!pend[st.held]) begin
          next_st.arb = uic_pkg::UIC_IDLE;
        end
      end
    endcase
    next_st.irq = (next_st.arb == uic_pkg::UIC_HELD);
    // Flow-stop flag; a stop in the same cycle as a resume wins
    next_st.xoff_flag = xoff_detected | (st.xoff_flag & ~xon_received);
    // Register writes
    if (wr) begin
      unique case (addr)
        uic_pkg::ADDR_DIV_LOW: begin
          if (dlab) begin
            next_st.div_low = wdata;
          end
        end
        uic_pkg::ADDR_DIV_HIGH: begin
          if (dlab) begin
            next_st.div_high = wdata;
          end
        end
        uic_pkg::ADDR_IDENT: begin
          if (dlab) begin
            next_st.feature = wdata;
          end
        end
        uic_pkg::ADDR_LINE: begin
          next_st.line_ctl = wdata;
        end
        default: begin
        end
      endcase
    end
    // Register reads, data one cycle later
    next_st.rdata = 8'h00;
    if (rd) begin
      unique case (addr)
        uic_pkg::ADDR_DIV_LOW: begin
          next_st.rdata = dlab ? st.div_low : 8'h00;
        end
        uic_pkg::ADDR_DIV_HIGH: begin
          next_st.rdata = dlab ? st.div_high : 8'h00;
        end
        uic_pkg::ADDR_IDENT: begin
          if (dlab) begin
            next_st.rdata = st.feature;
          end else begin
            next_st.rdata = {fifo_enabled ? uic_pkg::FIFO_ON : uic_pkg::FIFO_OFF,
                             ident_code};
          end
        end
        uic_pkg::ADDR_LINE: begin
          next_st.rdata = st.line_ctl;
        end
        default: begin
          next_st.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st <= '{arb: uic_pkg::UIC_IDLE, held: 3'h0, xoff_flag: 1'b0,
              line_ctl: uic_pkg::LCR_RESET, feature: uic_pkg::EFR_RESET,
              div_low: uic_pkg::DIV_RESET, div_high: uic_pkg::DIV_RESET,
              rdata: 8'h00, irq: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign irq = st.irq;
  assign divisor = {st.div_high, st.div_low};
  assign enhanced_mode = enh;

  uic_line_format u_fmt (
    .clk(clk),
    .rst_n(rst_sync_n),
    .line_ctl(st.line_ctl),
    .tx_serial(tx_serial),
    .tx_line(tx_line),
    .parity_enable(parity_enable),
    .parity_even(parity_even),
    .parity_forced(parity_forced),
    .parity_force_value(parity_force_value),
    .word_bits(word_bits),
    .stop_halves(stop_halves)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_sync_n);

  top_line_a: assert property (
    (st.arb == uic_pkg::UIC_IDLE && line_status_error) |=>
      (st.held == uic_pkg::SRC_LINE && ident_code == 6'h06))
    else $error("Line status error not presented first");

  rx_codes_a: assert property (
    (st.arb == uic_pkg::UIC_IDLE && receive_timeout && !line_status_error) |=>
      ident_code == 6'h0c)
    else $error("Receive time-out code wrong");

  low_codes_a: assert property (
    (st.arb == uic_pkg::UIC_IDLE && modem_status_change && pend[3:0] == 4'h0) |=>
      (ident_code == 6'h00 && irq))
    else $error("Modem status code wrong");

  flow_code_a: assert property (
    (st.arb == uic_pkg::UIC_IDLE && pend == 7'h40) |=> ident_code == 6'h20)
    else $error("Flow change code wrong");

  held_stable_a: assert property (
    (st.arb == uic_pkg::UIC_HELD && pend[st.held]) |=> $stable(st.held) && irq)
    else $error("Presented interrupt changed before service");

  enh_gate_a: assert property (
    !enh |-> ident_code[5:4] == 2'h0)
    else $error("Bits 5 and 4 set while enhanced mode off");

  xoff_hold_a: assert property (
    (st.xoff_flag && !xon_received) |=> st.xoff_flag)
    else $error("Flow-stop flag dropped without resume");

  fifo_bits_a: assert property (
    (rd && addr == uic_pkg::ADDR_IDENT && !dlab) |=>
      rdata[7:6] == {2{$past(fifo_enabled)}})
    else $error("FIFO bits wrong on identity read");

  irq_match_a: assert property (
    irq == (ident_code[0] == 1'b0))
    else $error("Interrupt output disagrees with status bit 0");

  div_gate_a: assert property (
    (wr && addr == uic_pkg::ADDR_DIV_LOW && !dlab) |=> $stable(divisor))
    else $error("Divisor written with access gate closed");

  rx_ready_a: assert property (
    (st.arb == uic_pkg::UIC_IDLE && receive_data_ready && !line_status_error &&
      !receive_timeout) |=> ident_code == 6'h04)
    else $error("Received data ready code wrong");

  thr_code_a: assert property (
    (st.arb == uic_pkg::UIC_IDLE && transmit_holding_empty && pend[2:0] == 3'h0) |=>
      (ident_code == 6'h02 && irq))
    else $error("Transmit holding empty code wrong");

  xoff_code_a: assert property (
    (st.arb == uic_pkg::UIC_IDLE && pend == 7'h20 && !wr) |=> ident_code == 6'h10)
    else $error("Flow-stop code wrong");

  xoff_set_a: assert property (
    xoff_detected |=> st.xoff_flag)
    else $error("Flow-stop flag not set");

  xoff_clear_a: assert property (
    (xon_received && !xoff_detected) |=> !st.xoff_flag)
    else $error("Flow-stop flag not cleared by resume");

  held_gap_a: assert property (
    (st.arb == uic_pkg::UIC_HELD && !pend[st.held]) |=> !irq)
    else $error("Serviced interrupt not released");

  ident_read_a: assert property (
    (rd && addr == uic_pkg::ADDR_IDENT && !dlab) |=> rdata[5:0] == $past(ident_code))
    else $error("Identity read does not return presented code");

  feature_gate_a: assert property (
    (wr && addr == uic_pkg::ADDR_IDENT && !dlab) |=> $stable(enhanced_mode))
    else $error("Enhanced feature written with access gate closed");

  div_high_gate_a: assert property (
    (wr && addr == uic_pkg::ADDR_DIV_HIGH && !dlab) |=> $stable(divisor))
    else $error("Divisor high written with access gate closed");

  div_read_gate_a: assert property (
    (rd && addr == uic_pkg::ADDR_DIV_LOW && !dlab) |=> rdata == 8'h00)
    else $error("Divisor readable with access gate closed");

  line_write_a: assert property (
    (wr && addr == uic_pkg::ADDR_LINE) |=> st.line_ctl == $past(wdata))
    else $error("Line control write lost");

  irq_rise_a: assert property (
    (st.arb == uic_pkg::UIC_IDLE && pick_any) |=> irq)
    else $error("Interrupt output not raised for pending source");

  line_read_a: assert property (
    (rd && addr == uic_pkg::ADDR_LINE) |=> rdata == $past(st.line_ctl))
    else $error("Line control read back wrong");

  reserved_read_a: assert property (
    (rd && addr[2]) |=> rdata == 8'h00)
    else $error("Unused address read not zero");
endmodule // uic_irq_ident

// File: common/uic_pkg.sv
// Constants, types and decoding shared by the interrupt identification and line control block.
// Assumes one system clock and a host reaching the registers over a plain strobe port.
package uic_pkg;

  localparam logic [2:0] ADDR_DIV_LOW = 3'h0;
  localparam logic [2:0] ADDR_DIV_HIGH = 3'h1;
  localparam logic [2:0] ADDR_IDENT = 3'h2;
  localparam logic [2:0] ADDR_LINE = 3'h3;

  localparam int LCR_DLAB = 7;
  localparam int LCR_BREAK = 6;
  localparam int LCR_STICK = 5;
  localparam int LCR_EVEN = 4;
  localparam int LCR_PAR_ON = 3;
  localparam int LCR_STOP = 2;
  localparam int EFR_ENH = 4;

  localparam logic [7:0] LCR_RESET = 8'h00;
  localparam logic [7:0] EFR_RESET = 8'h00;
  localparam logic [7:0] DIV_RESET = 8'h00;

  localparam logic [5:0] CODE_LINE = 6'h06;
  localparam logic [5:0] CODE_RXDATA = 6'h04;
  localparam logic [5:0] CODE_TIMEOUT = 6'h0c;
  localparam logic [5:0] CODE_THR = 6'h02;
  localparam logic [5:0] CODE_MODEM = 6'h00;
  localparam logic [5:0] CODE_XOFF = 6'h10;
  localparam logic [5:0] CODE_FLOW = 6'h20;
  localparam logic [5:0] CODE_NONE = 6'h01;
  localparam logic [1:0] FIFO_ON = 2'h3;
  localparam logic [1:0] FIFO_OFF = 2'h0;

  localparam int NUM_SRC = 7;
  localparam logic [2:0] SRC_LINE = 3'h0;
  localparam logic [2:0] SRC_TIMEOUT = 3'h1;
  localparam logic [2:0] SRC_RXDATA = 3'h2;
  localparam logic [2:0] SRC_THR = 3'h3;
  localparam logic [2:0] SRC_MODEM = 3'h4;
  localparam logic [2:0] SRC_XOFF = 3'h5;
  localparam logic [2:0] SRC_FLOW = 3'h6;

  localparam logic [3:0] WORD_BASE = 4'h5;
  localparam logic [2:0] STOP_ONE = 3'h2;
  localparam logic [2:0] STOP_ONE_HALF = 3'h3;
  localparam logic [2:0] STOP_TWO = 3'h4;

  typedef enum logic [1:0] {
    UIC_IDLE = 2'b01,
    UIC_HELD = 2'b10
  } uic_arb_t;

  // Identity code of one source
  function automatic logic [5:0] uic_code_of(input logic [2:0] src);
    logic [5:0] c;
    c = CODE_NONE;
    case (src)
      SRC_LINE: c = CODE_LINE;
      SRC_TIMEOUT: c = CODE_TIMEOUT;
      SRC_RXDATA: c = CODE_RXDATA;
      SRC_THR: c = CODE_THR;
      SRC_MODEM: c = CODE_MODEM;
      SRC_XOFF: c = CODE_XOFF;
      SRC_FLOW: c = CODE_FLOW;
      default: c = CODE_NONE;
    endcase
    return c;
  endfunction

endpackage

// File: rtl/uic_prio_pick.sv
// Priority picker over the pending interrupt sources.
// Assumes index 0 is the highest priority; purely combinational.
`timescale 1ns/10ps
module uic_prio_pick (
  input wire logic [uic_pkg::NUM_SRC-1:0] pending,
  output logic any,
  output logic [2:0] sel
);
  // Lowest index wins
  always_comb begin
    any = 1'b0;
    sel = 3'h0;
    for (int i = uic_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (pending[i]) begin
        any = 1'b1;
        sel = i[2:0];
      end
    end
  end
endmodule // uic_prio_pick

// File: rtl/uic_line_format.sv
// Line format decode and break control from the line control register.
// Assumes the synchronised reset of the top and a serial stream from the transmitter.
`timescale 1ns/10ps
module uic_line_format (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] line_ctl,
  input wire logic tx_serial,
  output logic tx_line,
  output logic parity_enable,
  output logic parity_even,
  output logic parity_forced,
  output logic parity_force_value,
  output logic [3:0] word_bits,
  output logic [2:0] stop_halves
);
  typedef struct packed {
    logic tx;
    logic par_en;
    logic par_even;
    logic par_forced;
    logic par_val;
    logic [3:0] word;
    logic [2:0] stop;
  } uic_fmt_t;

  uic_fmt_t st;
  uic_fmt_t next_st;

  always_comb begin
    next_st = st;
    next_st.tx = line_ctl[uic_pkg::LCR_BREAK] ? 1'b0 : tx_serial;
    next_st.par_en = line_ctl[uic_pkg::LCR_PAR_ON];
    next_st.par_forced = line_ctl[uic_pkg::LCR_PAR_ON] & line_ctl[uic_pkg::LCR_STICK];
    next_st.par_even = line_ctl[uic_pkg::LCR_PAR_ON] & ~line_ctl[uic_pkg::LCR_STICK]
      & line_ctl[uic_pkg::LCR_EVEN];
    next_st.par_val = ~line_ctl[uic_pkg::LCR_EVEN];
    next_st.word = uic_pkg::WORD_BASE + {2'h0, line_ctl[1:0]};
    if (!line_ctl[uic_pkg::LCR_STOP]) begin
      next_st.stop = uic_pkg::STOP_ONE;
    end else if (line_ctl[1:0] == 2'h0) begin
      next_st.stop = uic_pkg::STOP_ONE_HALF;
    end else begin
      next_st.stop = uic_pkg::STOP_TWO;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{tx: 1'b1, par_en: 1'b0, par_even: 1'b0, par_forced: 1'b0, par_val: 1'b1,
              word: uic_pkg::WORD_BASE, stop: uic_pkg::STOP_ONE};
    end else begin
      st <= next_st;
    end
  end

  assign tx_line = st.tx;
  assign parity_enable = st.par_en;
  assign parity_even = st.par_even;
  assign parity_forced = st.par_forced;
  assign parity_force_value = st.par_val;
  assign word_bits = st.word;
  assign stop_halves = st.stop;

  break_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(line_ctl[uic_pkg::LCR_BREAK]) |-> !tx_line)
    else $error("Transmit line not held low during break");

  stop_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(line_ctl[uic_pkg::LCR_STOP]) && $past(line_ctl[1:0]) == 2'h0) |->
      stop_halves == 3'h3)
    else $error("Five-bit words with long stop must give one and a half stop bits");

  word_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(line_ctl[1:0]) == 2'h3 |-> word_bits == 4'h8)
    else $error("Word length code 11 must give eight bits");
endmodule // uic_line_format

// File: verif/uic_host_model.sv
// Host processor model on the plain strobe register port.
// Assumes rdata is valid only in the cycle after the read strobe.
`timescale 1ns/10ps
module uic_host_model (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [2:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  initial begin
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  // One-cycle write strobe
  task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // One-cycle read strobe, data taken in the following cycle
  task automatic read_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
endmodule // uic_host_model

// File: verif/test_uart_irq_id_and_line_control.sv
// Self-checking bench for the interrupt identification and line control block.
// Assumes the host model drives the register port; sources come from here.
`timescale 1ns/10ps
module test_uart_irq_id_and_line_control;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic fifo_enabled = 1'b0;
  logic [5:0] src = 6'h00;
  logic xoff = 1'b0;
  logic xon = 1'b0;
  logic tx_serial = 1'b1;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, rv;
  logic wr, rd, irq, tx_line, enhanced_mode;
  logic par_en, par_even, par_forced, par_val;
  logic [15:0] divisor;
  logic [3:0] word_bits;
  logic [2:0] stop_halves;
  int error_cnt = 0;
  int total_checks = 0;
  logic [5:0] codes [5] = '{6'h06, 6'h0c, 6'h04, 6'h02, 6'h00};

  always #50 clk = ~clk;

  uic_host_model host_u (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

  uic_irq_ident dut_u (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .fifo_enabled(fifo_enabled), .line_status_error(src[0]),
    .receive_timeout(src[1]), .receive_data_ready(src[2]), .transmit_holding_empty(src[3]),
    .modem_status_change(src[4]), .flow_change(src[5]), .xoff_detected(xoff),
    .xon_received(xon), .tx_serial(tx_serial), .irq(irq), .tx_line(tx_line),
    .divisor(divisor), .enhanced_mode(enhanced_mode), .parity_enable(par_en),
    .parity_even(par_even), .parity_forced(par_forced), .parity_force_value(par_val),
    .word_bits(word_bits), .stop_halves(stop_halves));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    host_u.read_reg(a, rv);
    chk({8'h00, rv}, {8'h00, exp});
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic final_report();
    $display("Checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    final_report();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    wait_cyc(3);
    rd_chk(3'h2, 8'h01);
    chk({15'h0, irq}, 16'h0000);
    rd_chk(3'h3, 8'h00);
    rd_chk(3'h5, 8'h00);
    // Priority order from the five standard sources at once
    @(posedge clk);
    src <= 6'h1f;
    for (int i = 0; i < 5; i++) begin
      wait_cyc(4);
      rd_chk(3'h2, {2'b00, codes[i]});
      chk({15'h0, irq}, 16'h0001);
      if (i == 2) begin
        @(posedge clk);
        src[0] <= 1'b1;
        wait_cyc(4);
        rd_chk(3'h2, 8'h04);
      end
      @(posedge clk);
      src[i] <= 1'b0;
      src[0] <= 1'b0;
    end
    wait_cyc(4);
    rd_chk(3'h2, 8'h01);
    // Flow sources hidden while the enhanced bit is clear
    @(posedge clk);
    src[5] <= 1'b1;
    wait_cyc(4);
    rd_chk(3'h2, 8'h01);
    host_u.write_reg(3'h3, 8'h80);
    host_u.write_reg(3'h2, 8'h10);
    host_u.write_reg(3'h0, 8'h34);
    host_u.write_reg(3'h1, 8'h12);
    rd_chk(3'h0, 8'h34);
    host_u.write_reg(3'h3, 8'h00);
    wait_cyc(2);
    chk(divisor, 16'h1234);
    chk({15'h0, enhanced_mode}, 16'h0001);
    host_u.write_reg(3'h0, 8'h55);
    host_u.write_reg(3'h1, 8'haa);
    host_u.write_reg(3'h2, 8'h00);
    rd_chk(3'h0, 8'h00);
    chk(divisor, 16'h1234);
    chk({15'h0, enhanced_mode}, 16'h0001);
    wait_cyc(2);
    rd_chk(3'h2, 8'h20);
    @(posedge clk);
    src[5] <= 1'b0;
    wait_cyc(4);
    @(posedge clk);
    xoff <= 1'b1;
    @(posedge clk);
    xoff <= 1'b0;
    wait_cyc(8);
    rd_chk(3'h2, 8'h10);
    @(posedge clk);
    xon <= 1'b1;
    @(posedge clk);
    xon <= 1'b0;
    wait_cyc(4);
    rd_chk(3'h2, 8'h01);
    @(posedge clk);
    fifo_enabled <= 1'b1;
    wait_cyc(2);
    rd_chk(3'h2, 8'hc1);
    // Word length and stop length combinations
    for (int i = 0; i < 8; i++) begin
      host_u.write_reg(3'h3, 8'(i));
      wait_cyc(2);
      chk({12'h0, word_bits}, 16'(5 + i % 4));
      chk({13'h0, stop_halves}, (i < 4) ? 16'h2 : (i == 4) ? 16'h3 : 16'h4);
      rd_chk(3'h3, 8'(i));
    end
    // Parity modes: none, odd, even, forced 1, forced 0
    for (int i = 0; i < 5; i++) begin
      host_u.write_reg(3'h3, (i == 0) ? 8'h00 : 8'(8'h08 + 8'h10 * (i - 1)));
      wait_cyc(2);
      chk({12'h0, par_en, par_even, par_forced, par_val},
        (i == 0) ? 16'h1 : (i == 1) ? 16'h9 : (i == 2) ? 16'hc : (i == 3) ? 16'hb : 16'ha);
    end
    // Break forces the line low until cleared
    host_u.write_reg(3'h3, 8'h43);
    wait_cyc(2);
    chk({15'h0, tx_line}, 16'h0000);
    host_u.write_reg(3'h3, 8'h03);
    wait_cyc(2);
    chk({15'h0, tx_line}, 16'h0001);
    @(posedge clk);
    tx_serial <= 1'b0;
    wait_cyc(2);
    chk({15'h0, tx_line}, 16'h0000);
    final_report();
  end
endmodule // test_uart_irq_id_and_line_control
